// file: pkg/dtf_defs.svh
// Task-file addresses, field positions and timing counts
// Assumes a 25 MHz clock; included by bare name
`ifndef DTF_DEFS_SVH
`define DTF_DEFS_SVH
// Task-file addresses {cs1 select, ha2..ha0}
`define DTF_ADDR_SECTOR     4'h3
`define DTF_ADDR_CYL_LOW    4'h4
`define DTF_ADDR_CYL_HIGH   4'h5
`define DTF_ADDR_DRIVE_HEAD 4'h6
`define DTF_ADDR_STATUS     4'h7
`define DTF_ADDR_SHADOW     4'he
// Status bits
`define DTF_ST_BUSY   7
`define DTF_ST_READY  6
`define DTF_ST_FAULT  5
`define DTF_ST_SEEK   4
`define DTF_ST_DREQ   3
`define DTF_ST_ECC    2
`define DTF_ST_INDEX  1
`define DTF_ST_ERR    0
// Drive/head fields
`define DTF_DH_SLAVE  4
`define DTF_DH_FIXED  8'ha0
// Control bits
`define DTF_CTL_RST   2
`define DTF_CTL_IDS   1
`define DTF_CYL_HIGH_MASK 8'h07
// Timing
`define DTF_CLK_HZ        25000000
`define DTF_RST_MIN_NS    5000
`define DTF_RST_MIN_CYC   ((`DTF_RST_MIN_NS * 25 + 999) / 1000)
`define DTF_PASS_WAIT_MS  3
`define DTF_PASS_WAIT_CYC (`DTF_PASS_WAIT_MS * (`DTF_CLK_HZ / 1000))
`endif

// file: pkg/dtf_pkg.sv
// Types for the disk task-file register bank
// Assumes nothing beyond a SystemVerilog compiler
package dtf_pkg;
   typedef enum logic [3:0] {
      DTF_IDLE   = 4'b0001,
      DTF_EXEC   = 4'b0010,
      DTF_RESET  = 4'b0100,
      DTF_WAIT   = 4'b1000
   } dtf_state_e;

   // Command request to the drive engine
   typedef struct packed {
      logic       valid;
      logic [7:0] code;
      logic [7:0] sector;
      logic [10:0] cylinder;
      logic [3:0] head;
   } dtf_cmd_s;

   // Completion report from the drive engine
   typedef struct packed {
      logic done;
      logic error;
      logic corrected;
   } dtf_done_s;
endpackage

// file: hw/dtf_task_file.sv
// Host-visible task-file register bank of a disk drive interface
// Assumes task-file pins arrive asynchronous and a drive engine on clk
//
// Functional notes
// - Target sector register gives starting sector
// - Cylinder split: eight low, three high bits
// - Drive bit one selects slave, zero master
// - Low four bits give the head number
// - Reading status clears pending interrupt
// - Busy set on request, cleared on completion
// - While busy, other reads return status
// - Not ready refuses or aborts commands
// - Write fault aborts; commands refused meanwhile
// - Seek done flag after last seek
// - Data request flag while data waits
// - Corrected flag after repaired sector
// - Index flag follows index pulse
// - Error flag on unrecoverable error
// - Command write sets busy at once
// - Shadow status reads without clearing interrupt
// - Control reset bit holds drive in reset
// - Slave drops pass signal during reset
// - Master waits up to 3 ms for pass
// - Interrupt disable floats line, keeps pending
// - Interrupts disabled after master reset
`include "dtf_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module dtf_task_file #(
   parameter int PASS_WAIT_CYC = `DTF_PASS_WAIT_CYC,
   parameter int RST_MIN_CYC   = `DTF_RST_MIN_CYC
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // Task-file bus pins
   input  wire logic              cs0_n,
   input  wire logic              cs1_n,
   input  wire logic [2:0]        host_addr,
   input  wire logic              rd_n,
   input  wire logic              wr_n,
   input  wire logic [7:0]        host_wdata,
   output logic      [7:0]        host_rdata,
   output logic                   host_rdata_oe,
   output logic                   host_irq_line,
   output logic                   host_irq_line_oe,
   // Dual-drive strap and pass line
   input  wire logic              is_slave,
   input  wire logic              slave_pass_signal_in,
   output logic                   slave_pass_signal,
   output logic                   slave_pass_signal_oe,
   // Drive engine side
   input  wire logic              drive_ready,
   input  wire logic              write_fault,
   input  wire logic              seek_done,
   input  wire logic              data_waiting,
   input  wire logic              index_pulse,
   input  wire dtf_pkg::dtf_done_s engine_done,
   output dtf_pkg::dtf_cmd_s      engine_cmd,
   output logic                   engine_abort,
   output logic                   drive_reset
);

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   logic [15:0] sync_a;
   logic [15:0] sync_b;
   logic [7:0]  wdata_a;
   logic [7:0]  wdata_b;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync_a  <= 16'hfe03; // Strobes idle, strap and levels low
         sync_b  <= 16'hfe03;
         wdata_a <= 8'h00;
         wdata_b <= 8'h00;
      end else begin
         sync_a  <= {cs0_n, cs1_n, host_addr, rd_n, wr_n, is_slave, slave_pass_signal_in,
                     drive_ready, write_fault, seek_done, data_waiting, index_pulse, 2'b11};
         sync_b  <= sync_a;
         wdata_a <= host_wdata;
         wdata_b <= wdata_a;
      end
   end

   logic       s_cs0_n, s_cs1_n, s_rd_n, s_wr_n, s_slave, s_pass;
   logic       s_ready, s_fault, s_seek, s_dreq, s_index;
   logic [2:0] s_addr;
   assign {s_cs0_n, s_cs1_n, s_addr, s_rd_n, s_wr_n, s_slave, s_pass,
           s_ready, s_fault, s_seek, s_dreq, s_index} = sync_b[15:2];

   // Edge detect on the synchronised strobes only
   logic rd_q, wr_q;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_q <= 1'b1;
         wr_q <= 1'b1;
      end else begin
         rd_q <= s_rd_n;
         wr_q <= s_wr_n;
      end
   end
   logic       rd_pulse, wr_pulse, rd_active;
   logic [3:0] sel;
   logic       sel_ok;
   assign rd_active = !s_rd_n;
   assign rd_pulse  = rd_q && !s_rd_n;
   assign wr_pulse  = !wr_q && s_wr_n;   // Data is taken at the trailing edge
   assign sel       = {!s_cs1_n, s_addr};
   assign sel_ok    = s_cs0_n ^ s_cs1_n;

   // Strap reads as master until it has crossed the synchroniser,
   // so a master never pulls the pass line low just after reset
   logic slave_mode;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         slave_mode <= 1'b0;
      else
         slave_mode <= s_slave;
   end

   // ==========================================================
   // Task-file registers
   // ==========================================================
   logic [7:0] target_sector;
   logic [7:0] cylinder_low_byte;
   logic [7:0] cylinder_high_bits;
   logic [7:0] drive_head_register;
   logic [7:0] host_control;
   logic       busy_flag;

   function automatic logic wr_hit(input logic [3:0] a);
      wr_hit = wr_pulse && sel_ok && (sel == a);
   endfunction

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         target_sector       <= 8'h01;
         cylinder_low_byte   <= 8'h00;
         cylinder_high_bits  <= 8'h00;
         drive_head_register <= `DTF_DH_FIXED;
      end else if (!busy_flag) begin
         if (wr_hit(`DTF_ADDR_SECTOR))
            target_sector <= wdata_b;
         if (wr_hit(`DTF_ADDR_CYL_LOW))
            cylinder_low_byte <= wdata_b;
         if (wr_hit(`DTF_ADDR_CYL_HIGH))
            cylinder_high_bits <= wdata_b & `DTF_CYL_HIGH_MASK;
         if (wr_hit(`DTF_ADDR_DRIVE_HEAD))
            drive_head_register <= wdata_b;
      end
   end

   // Control register; interrupts start disabled
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         host_control <= 8'h02;
      else if (wr_hit(`DTF_ADDR_SHADOW))
         host_control <= wdata_b & 8'h06;
   end

   logic selected;
   assign selected = (drive_head_register[`DTF_DH_SLAVE] == slave_mode);

   // ==========================================================
   // Command sequencing and reset handshake
   // ==========================================================
   dtf_pkg::dtf_state_e state;
   logic [31:0] wait_cnt;
   logic        cmd_wr, refuse, abort_now;
   logic        err_flag, ecc_flag, irq_pending;
   assign cmd_wr    = wr_hit(`DTF_ADDR_STATUS) && selected;
   assign refuse    = !s_ready || s_fault;
   assign abort_now = (state == dtf_pkg::DTF_EXEC) && refuse;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state      <= dtf_pkg::DTF_RESET;
         busy_flag  <= 1'b1;
         wait_cnt   <= 32'd0;
         engine_cmd <= '0;
         engine_abort <= 1'b0;
         err_flag   <= 1'b0;
         ecc_flag   <= 1'b0;
      end else begin
         engine_cmd.valid <= 1'b0;
         engine_abort     <= 1'b0;
         if (host_control[`DTF_CTL_RST]) begin
            state     <= dtf_pkg::DTF_RESET;
            busy_flag <= 1'b1;
            wait_cnt  <= 32'd0;
         end else begin
            unique case (state)
               dtf_pkg::DTF_RESET: begin
                  // Minimum local routine time, then the pass handshake
                  if (wait_cnt >= 32'(RST_MIN_CYC)) begin
                     state    <= slave_mode ? dtf_pkg::DTF_IDLE : dtf_pkg::DTF_WAIT;
                     busy_flag <= !slave_mode;
                     wait_cnt <= 32'd0;
                  end else
                     wait_cnt <= wait_cnt + 32'd1;
               end
               dtf_pkg::DTF_WAIT: begin
                  if (s_pass || wait_cnt >= 32'(PASS_WAIT_CYC)) begin
                     state     <= dtf_pkg::DTF_IDLE;
                     busy_flag <= 1'b0;
                  end else
                     wait_cnt <= wait_cnt + 32'd1;
               end
               dtf_pkg::DTF_IDLE: begin
                  if (cmd_wr) begin
                     busy_flag <= 1'b1;
                     ecc_flag  <= 1'b0;
                     if (refuse) begin
                        err_flag <= 1'b1;
                        state    <= dtf_pkg::DTF_EXEC;
                     end else begin
                        err_flag <= 1'b0;
                        state    <= dtf_pkg::DTF_EXEC;
                        engine_cmd.valid    <= 1'b1;
                        engine_cmd.code     <= wdata_b;
                        engine_cmd.sector   <= target_sector;
                        engine_cmd.cylinder <= {cylinder_high_bits[2:0], cylinder_low_byte};
                        engine_cmd.head     <= drive_head_register[3:0];
                     end
                  end
               end
               dtf_pkg::DTF_EXEC: begin
                  // Refused commands finish here on the next cycle with error set
                  if (abort_now || engine_done.done || err_flag) begin
                     busy_flag    <= 1'b0;
                     state        <= dtf_pkg::DTF_IDLE;
                     engine_abort <= abort_now && !err_flag;
                     if (abort_now || engine_done.error)
                        err_flag <= 1'b1;
                     if (engine_done.corrected)
                        ecc_flag <= 1'b1;
                  end
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Status and interrupt
   // ==========================================================
   logic [7:0] drive_status;
   always_comb begin
      drive_status = 8'h00;
      drive_status[`DTF_ST_BUSY]  = busy_flag;
      drive_status[`DTF_ST_READY] = s_ready;
      drive_status[`DTF_ST_FAULT] = s_fault;
      drive_status[`DTF_ST_SEEK]  = s_seek;
      drive_status[`DTF_ST_DREQ]  = s_dreq;
      drive_status[`DTF_ST_ECC]   = ecc_flag;
      drive_status[`DTF_ST_INDEX] = s_index;
      drive_status[`DTF_ST_ERR]   = err_flag;
   end

   logic done_evt;
   assign done_evt = (state == dtf_pkg::DTF_EXEC) && !host_control[`DTF_CTL_RST]
                     && (abort_now || engine_done.done || err_flag);

   // Completion wins over a status read in the same cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         irq_pending <= 1'b0;
      else if (done_evt)
         irq_pending <= 1'b1;
      else if (rd_pulse && sel_ok && sel == `DTF_ADDR_STATUS && selected)
         irq_pending <= 1'b0;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         host_irq_line    <= 1'b0;
         host_irq_line_oe <= 1'b0;
      end else begin
         host_irq_line    <= irq_pending && selected;
         host_irq_line_oe <= !host_control[`DTF_CTL_IDS] && selected;
      end
   end

   // ==========================================================
   // Read path
   // ==========================================================
   logic [7:0] next_rdata;
   always_comb begin
      next_rdata = 8'h00;
      if (busy_flag && sel != `DTF_ADDR_SHADOW)
         next_rdata = drive_status;
      else begin
         unique case (sel)
            `DTF_ADDR_SECTOR:     next_rdata = target_sector;
            `DTF_ADDR_CYL_LOW:    next_rdata = cylinder_low_byte;
            `DTF_ADDR_CYL_HIGH:   next_rdata = cylinder_high_bits;
            `DTF_ADDR_DRIVE_HEAD: next_rdata = drive_head_register;
            `DTF_ADDR_STATUS:     next_rdata = drive_status;
            `DTF_ADDR_SHADOW:     next_rdata = drive_status;
            default:              next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         host_rdata    <= 8'h00;
         host_rdata_oe <= 1'b0;
      end else begin
         host_rdata    <= next_rdata;
         host_rdata_oe <= rd_active && sel_ok && selected;
      end
   end

   // ==========================================================
   // Drive reset and pass line
   // ==========================================================
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         drive_reset          <= 1'b1;
         slave_pass_signal    <= 1'b0;
         slave_pass_signal_oe <= 1'b0;
      end else begin
         drive_reset          <= host_control[`DTF_CTL_RST] || state == dtf_pkg::DTF_RESET;
         slave_pass_signal    <= 1'b0;
         // Open-drain, active low: pulled low while the slave is resetting
         slave_pass_signal_oe <= slave_mode && state == dtf_pkg::DTF_RESET;
      end
   end

endmodule
`default_nettype wire

// file: sim/dtf_host_model.sv
// Host adapter model that drives the task-file bus
// Assumes one bench process calls wr and rd, never both at once
`timescale 1ns/1ps
`default_nettype none
module dtf_host_model (
   // Clock
   input  wire logic       clk,
   // Task-file bus
   output logic            cs0_n,
   output logic            cs1_n,
   output logic [2:0]      host_addr,
   output logic            rd_n,
   output logic            wr_n,
   output logic [7:0]      host_wdata,
   input  wire logic [7:0] host_rdata,
   input  wire logic       host_rdata_oe,
   // Read results
   output logic            rd_seen,
   output logic [7:0]      rd_val
);
   // ========
   // Bus cycles
   initial begin
      {cs1_n, cs0_n, rd_n, wr_n} = 4'hf;
      host_addr = 3'h0;
      host_wdata = 8'h00;
      rd_seen = 1'b0;
      rd_val = 8'h00;
   end
   task automatic sel_on(input logic [3:0] a);
      {cs1_n, cs0_n} <= a[3] ? 2'b01 : 2'b10;
      host_addr <= a[2:0];
   endtask
   // Data held past the strobe edge plus the sync delay, then scrambled
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      sel_on(a);
      host_wdata <= d;
      wr_n <= 1'b0;
      repeat (4) @(posedge clk);
      wr_n <= 1'b1;
      repeat (5) @(posedge clk);
      {cs1_n, cs0_n} <= 2'b11;
      host_wdata <= ~d;
   endtask
   task automatic rd(input logic [3:0] a, input logic chk);
      @(posedge clk);
      sel_on(a);
      rd_n <= 1'b0;
      @(posedge clk);
      while (host_rdata_oe !== 1'b1) @(posedge clk);
      rd_val <= host_rdata;
      rd_seen <= chk;
      rd_n <= 1'b1;
      @(posedge clk);
      rd_seen <= 1'b0;
      repeat (4) @(posedge clk);
      {cs1_n, cs0_n} <= 2'b11;
   endtask
endmodule
`default_nettype wire

// file: sim/dtf_task_file_chk.sv
// Port checker for the task-file register bank
// Assumes binding to dtf_task_file, one clock domain
`timescale 1ns/1ps
`default_nettype none
module dtf_task_file_chk (
   // Clock and reset
   input wire logic              clk,
   input wire logic              reset_n,
   // Watched ports
   input wire logic              drive_ready,
   input wire logic              write_fault,
   input wire logic              is_slave,
   input wire logic [7:0]        host_rdata,
   input wire logic              host_rdata_oe,
   input wire logic              host_irq_line,
   input wire logic              host_irq_line_oe,
   input wire logic              slave_pass_signal_oe,
   input wire dtf_pkg::dtf_done_s engine_done,
   input wire dtf_pkg::dtf_cmd_s  engine_cmd,
   input wire logic              engine_abort
);
   // ========
   // Helpers and properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic [3:0] bad_cnt;
   logic       exec;
   // Bad-drive run length; saturates so long outages stay flagged
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) bad_cnt <= 4'h0;
      else if (drive_ready && !write_fault) bad_cnt <= 4'h0;
      else if (bad_cnt != 4'hf) bad_cnt <= bad_cnt + 4'h1;
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) exec <= 1'b0;
      else if (engine_cmd.valid) exec <= 1'b1;
      else if (engine_done.done || engine_abort) exec <= 1'b0;
   end
   sequence s_done;
      engine_done.done && exec && host_irq_line_oe;
   endsequence
   sequence s_irq_up;
      ##[1:4] host_irq_line;
   endsequence
   a_cmd_pulse: assert property (engine_cmd.valid |=> !engine_cmd.valid)
      else $error("command request longer than one cycle");
   a_no_recmd: assert property (exec |-> !engine_cmd.valid)
      else $error("command issued while busy");
   a_busy_read: assert property (exec && host_rdata_oe && $past(host_rdata_oe) |-> host_rdata[7])
      else $error("busy read without busy bit");
   a_done_irq: assert property (s_done |-> s_irq_up)
      else $error("completion raised no interrupt");
   a_refuse_bad: assert property (bad_cnt > 4'h5 |-> !engine_cmd.valid)
      else $error("command passed on while drive not usable");
   a_abort_drop: assert property (bad_cnt == 4'h8 |-> !exec)
      else $error("running command not aborted");
   a_irq_off: assert property ($rose(reset_n) |-> !host_irq_line_oe [*8])
      else $error("interrupt line driven after reset");
   a_master_pass: assert property (!is_slave && !$past(is_slave, 4) |-> !slave_pass_signal_oe)
      else $error("master pulled pass line");
endmodule
bind dtf_task_file dtf_task_file_chk dtf_task_file_chk_i (.clk, .reset_n, .drive_ready,
   .write_fault, .is_slave, .host_rdata, .host_rdata_oe, .host_irq_line, .host_irq_line_oe,
   .slave_pass_signal_oe, .engine_done, .engine_cmd, .engine_abort);
`default_nettype wire

// file: sim/tb_dtf_task_file.sv
// Bench for the task-file register bank with host model and engine stub
// Assumes package, design, checker and host model compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_dtf_task_file;
   // ========
   // Wiring
   localparam int PW = 50;
   logic        clk, reset_n, drive_ready, write_fault, index_pulse, pass_drv, respond;
   logic        is_slave, seek_done, data_waiting;
   logic        cs0_n, cs1_n, rd_n, wr_n, host_rdata_oe, host_irq_line, host_irq_line_oe;
   logic        slave_pass_signal, slave_pass_signal_oe, engine_abort, drive_reset;
   logic [2:0]  host_addr;
   logic [7:0]  host_wdata, host_rdata, exp_st [4];
   logic [31:0] cyc, t0, c, s;
   logic [30:0] cq [$];
   logic [7:0]  rq [$];
   int          error_cnt = 0, checked = 0, seed = 68, n_abort = 0;
   dtf_pkg::dtf_done_s engine_done;
   dtf_pkg::dtf_cmd_s  engine_cmd;
   // Open-drain pass line: the far slave asserts high unless pulled low
   wire         pass_line = pass_drv & ~slave_pass_signal_oe;
   dtf_task_file #(.PASS_WAIT_CYC(PW), .RST_MIN_CYC(4)) dtf_task_file_i (.clk, .reset_n,
      .cs0_n, .cs1_n, .host_addr, .rd_n, .wr_n, .host_wdata, .host_rdata, .host_rdata_oe,
      .host_irq_line, .host_irq_line_oe, .is_slave, .slave_pass_signal_in(pass_line),
      .slave_pass_signal, .slave_pass_signal_oe, .drive_ready, .write_fault,
      .seek_done, .data_waiting, .index_pulse, .engine_done, .engine_cmd,
      .engine_abort, .drive_reset);
   dtf_host_model dtf_host_model_i (.clk, .cs0_n, .cs1_n, .host_addr, .rd_n, .wr_n,
      .host_wdata, .host_rdata, .host_rdata_oe, .rd_seen(), .rd_val());
   // ========
   // Checking and helpers
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic summarize;
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      rq.push_back(e);
      dtf_host_model_i.rd(a, 1'b1);
   endtask
   // Polls the shadow copy so a pending interrupt survives the wait
   task automatic wait_idle;
      do dtf_host_model_i.rd(4'he, 1'b0);
      while (dtf_host_model_i.rd_val[7] !== 1'b0);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 32'd1;
      if (cyc == 32'd20000) begin
         error_cnt++;
         summarize();
      end
   end
   always @(posedge clk) begin
      if (dtf_host_model_i.rd_seen === 1'b1) check("rdata", dtf_host_model_i.rd_val, rq.pop_front());
      if (engine_cmd.valid === 1'b1) check("cmd", engine_cmd[30:0], cq.pop_front());
      if (engine_abort === 1'b1) n_abort++;
   end
   always @(posedge clk) begin
      if (engine_cmd.valid === 1'b1 && respond) begin
         repeat (20) @(posedge clk);
         engine_done <= 3'b101;
         @(posedge clk);
         engine_done <= 3'b000;
      end
   end
   // ========
   // Scenarios
   initial begin
      reset_n = 1'b0;
      {drive_ready, write_fault, index_pulse, pass_drv, respond, is_slave, seek_done,
       data_waiting} = 8'h8b;
      engine_done = 3'b000;
      cyc = 32'd0;
      exp_st = '{8'h09, 8'h71, 8'h1b, 8'h5c};
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      wait_idle();
      rd_chk(4'h3, 8'h01);
      rd_chk(4'h4, 8'h00);
      rd_chk(4'h6, 8'ha0);
      s = $random(seed);
      c = $random(seed);
      dtf_host_model_i.wr(4'h3, s[7:0]);
      dtf_host_model_i.wr(4'h4, c[7:0]);
      dtf_host_model_i.wr(4'h5, c[15:8]);
      dtf_host_model_i.wr(4'h6, {4'ha, c[19:16]});
      rd_chk(4'h5, c[15:8] & 8'h07);
      rd_chk(4'h6, {4'ha, c[19:16]});
      cq.push_back({8'h20, s[7:0], c[10:0], c[19:16]});
      dtf_host_model_i.wr(4'h7, 8'h20);
      rd_chk(4'h3, 8'hd8);
      wait_idle();
      check("irq_oe", host_irq_line_oe, 32'd0);
      dtf_host_model_i.wr(4'he, 8'h00);
      repeat (3) @(posedge clk);
      check("irq_oe", host_irq_line_oe, 32'd1);
      check("irq", host_irq_line, 32'd1);
      rd_chk(4'he, 8'h5c);
      check("irq", host_irq_line, 32'd1);
      rd_chk(4'h7, 8'h5c);
      check("irq", host_irq_line, 32'd0);
      // Not ready, fault, ready lost mid-run, then a clean run
      for (int k = 0; k < 4; k++) begin
         drive_ready <= (k != 0);
         write_fault <= (k == 1);
         index_pulse <= (k == 2);
         seek_done <= (k != 0);
         data_waiting <= (k != 1);
         respond = (k == 3);
         repeat (8) @(posedge clk);
         if (k > 1) cq.push_back({8'h30, s[7:0], c[10:0], c[19:16]});
         dtf_host_model_i.wr(4'h7, 8'h30);
         if (k == 2) drive_ready <= 1'b0;
         wait_idle();
         rd_chk(4'h7, exp_st[k]);
      end
      check("aborts", n_abort, 32'd1);
      // Soft reset: silent slave, answering slave, then this drive as the slave
      for (int k = 0; k < 3; k++) begin
         pass_drv <= k[0];
         if (k == 2) begin
            is_slave <= 1'b1;
            dtf_host_model_i.wr(4'h6, 8'hb0);
            rd_chk(4'h6, 8'hb0);
         end
         dtf_host_model_i.wr(4'he, 8'h04);
         repeat (130) @(posedge clk);
         check("drive_reset", drive_reset, 32'd1);
         check("pass_oe", slave_pass_signal_oe, k == 2);
         dtf_host_model_i.wr(4'he, 8'h00);
         t0 = cyc;
         wait_idle();
         check("pass_wait", cyc - t0 >= PW, k == 0);
         check("drive_reset", drive_reset, 32'd0);
         check("pass_line", {slave_pass_signal, slave_pass_signal_oe}, 32'd0);
      end
      summarize();
   end
endmodule
`default_nettype wire
